/* File: rtl/fcs_flash_host.sv */
// Summary of operation
// - B0h suspends a program; host then reads other addresses or status.
// - D0h resumes a suspended program; the sequencer continues it.
// - Erase is setup 20h then confirm D0h at an address inside the block.
// - During erase suspend host touches other blocks, then resumes with D0h.
// - Powerdown reset low clears the device; host waits recovery time afterwards.
// - Powerdown reset during program or erase aborts it; operation must repeat.
// - Two AFh writes enter one-time mode; program there targets that area.
// - Two FFh writes leave one-time mode back to read array.
// - Lock query: 70h with an address in the block, valid with protect low.
// - Status bit seven is zero while busy and one when ready.
// - Host writes FFh after the last program to return to read array.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_consts.svh"

module fcs_flash_host
  import fcs_pkg::*;
#(
  parameter int ADDR_W  = 20,
  parameter int DATA_W  = 16,
  parameter int T_RS_NS = `FCS_T_RS_NS
) (
  // Clock and reset.
  input  wire logic                clk_sys_i,
  input  wire logic                srst_i,
  // APB slave.
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Flash pins.
  output logic      [ADDR_W-1:0]   fl_addr_o,
  input  wire logic [DATA_W-1:0]   fl_dq_i,
  output logic      [DATA_W-1:0]   fl_dq_o,
  output logic                     fl_dq_oe_o,
  output logic                     fl_ce_n_o,
  output logic                     fl_oe_n_o,
  output logic                     fl_we_n_o,
  output logic                     powerdown_reset_n_o,
  output logic                     fl_wp_n_o
);

  localparam logic [7:0]  T_WP_C  = 8'(`FCS_NS2CYC(`FCS_T_WP_NS));
  localparam logic [7:0]  T_WPH_C = 8'(`FCS_NS2CYC(`FCS_T_WPH_NS));
  localparam logic [7:0]  T_ACC_C = 8'(`FCS_NS2CYC(`FCS_T_ACC_NS));
  localparam logic [15:0] T_RS_C  = 16'(`FCS_NS2CYC(T_RS_NS));

  // Sequence of bus steps for each operation.
  function automatic fcs_step_t step_of(input logic [3:0] op, input logic [2:0] idx);
    fcs_step_t s;
    s = '{K_END, `FCS_CMD_NONE};
    case (op)
      `FCS_OP_RD_ARRAY:   s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_READ_ARRAY} :
                              (idx == 3'd1) ? fcs_step_t'{K_READ, `FCS_CMD_NONE} : s;
      `FCS_OP_RD_STATUS:  s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_READ_STATUS} :
                              (idx == 3'd1) ? fcs_step_t'{K_READ, `FCS_CMD_NONE} : s;
      `FCS_OP_PROGRAM:    s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_PROG_SETUP} :
                              (idx == 3'd1) ? fcs_step_t'{K_WDAT, `FCS_CMD_NONE} : s;
      `FCS_OP_ERASE:      s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_ERASE_SETUP} :
                              (idx == 3'd1) ? fcs_step_t'{K_WCMD, `FCS_CMD_CONFIRM} : s;
      `FCS_OP_SUSPEND:    s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_SUSPEND} :
                              (idx == 3'd1) ? fcs_step_t'{K_POLL, `FCS_CMD_NONE} : s;
      `FCS_OP_RESUME:     s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_CONFIRM} : s;
      `FCS_OP_OTP_ENTER:  s = (idx < 3'd2) ? fcs_step_t'{K_WCMD, `FCS_CMD_OTP} : s;
      `FCS_OP_OTP_EXIT:   s = (idx < 3'd2) ? fcs_step_t'{K_WCMD, `FCS_CMD_READ_ARRAY} : s;
      `FCS_OP_OTP_PROG:   s = (idx < 3'd2)  ? fcs_step_t'{K_WCMD, `FCS_CMD_OTP} :
                              (idx == 3'd2) ? fcs_step_t'{K_WCMD, `FCS_CMD_PROG_SETUP} :
                              (idx == 3'd3) ? fcs_step_t'{K_WDAT, `FCS_CMD_NONE} : s;
      `FCS_OP_PROTECT:    s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_PROTECT} :
                              (idx == 3'd1) ? fcs_step_t'{K_WDAT, `FCS_CMD_NONE} : s;
      `FCS_OP_CLR_STATUS: s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_CLR_STATUS} : s;
      `FCS_OP_POLL:       s = (idx == 3'd0) ? fcs_step_t'{K_WCMD, `FCS_CMD_READ_STATUS} :
                              (idx == 3'd1) ? fcs_step_t'{K_POLL, `FCS_CMD_NONE} : s;
      `FCS_OP_RD_RAW:     s = (idx == 3'd0) ? fcs_step_t'{K_READ, `FCS_CMD_NONE} : s;
      default:            s = '{K_END, `FCS_CMD_NONE};
    endcase
    return s;
  endfunction

  // Operations that start work in the device's write sequencer.
  function automatic logic op_starts_work(input logic [3:0] op);
    return (op == `FCS_OP_PROGRAM) || (op == `FCS_OP_ERASE) ||
           (op == `FCS_OP_OTP_PROG) || (op == `FCS_OP_RESUME);
  endfunction

  // Software registers and engine state.
  logic [3:0]        op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic [7:0]        sr_r;
  logic              rst_pin_r;
  logic              wp_pin_r;
  logic              refused_r;
  logic              dev_busy_r;
  logic              susp_r;
  logic              eng_busy_r;
  logic [15:0]       rec_cnt_r;
  fcs_state_t        state_r;
  logic [2:0]        idx_r;
  logic [7:0]        cnt_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;

  // APB decode.
  wire logic       apb_setup  = psel_i & penable_i & ~pready_r;
  wire logic       apb_commit = psel_i & penable_i & pready_r & pwrite_i;
  wire logic       hit_ctrl   = paddr_i == `FCS_REG_CTRL;
  wire logic       hit_addr   = paddr_i == `FCS_REG_ADDR;
  wire logic       hit_wdata  = paddr_i == `FCS_REG_WDATA;
  wire logic       hit_rdata  = paddr_i == `FCS_REG_RDATA;
  wire logic       hit_status = paddr_i == `FCS_REG_STATUS;
  wire logic       hit_pins   = paddr_i == `FCS_REG_PINS;
  wire logic       hit_any    = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_status | hit_pins;
  wire logic [3:0] new_op     = pwdata_i[3:0];
  wire logic       recovering = rec_cnt_r != 16'h0000;

  // While the device sequencer is busy only suspend, status polling, status reads and raw reads may go out.
  wire logic op_ok_busy = (new_op == `FCS_OP_SUSPEND) || (new_op == `FCS_OP_POLL) ||
                          (new_op == `FCS_OP_RD_STATUS) || (new_op == `FCS_OP_RD_RAW);
  wire logic op_valid   = new_op <= `FCS_OP_RD_RAW;
  wire logic start_req  = apb_commit & hit_ctrl;
  // No command goes out while reset is low or during recovery.
  wire logic start_ok   = op_valid & ~eng_busy_r & rst_pin_r & ~recovering & (~dev_busy_r | op_ok_busy);
  wire logic start      = start_req & start_ok;
  wire logic refuse_clr = apb_commit & hit_status & pwdata_i[`FCS_ST_REFUSED];

  wire fcs_step_t cur_step = step_of(op_r, idx_r);
  wire logic      rd_done  = (state_r == ST_RD_LOW) && (cnt_r == 8'h00);
  wire logic      poll_rdy = rd_done && (cur_step.kind == K_POLL) && fl_dq_i[`FCS_SR_READY];

  // Read data mux for the APB.
  wire logic [31:0] rd_mux =
    hit_ctrl   ? {28'h0000000, op_r} :
    hit_addr   ? 32'(addr_r) :
    hit_wdata  ? 32'(wdata_r) :
    hit_rdata  ? 32'(rdata_r) :
    hit_status ? {16'h0000, sr_r, 3'b000, susp_r, recovering, refused_r, dev_busy_r, eng_busy_r} :
    hit_pins   ? {30'h00000000, wp_pin_r, rst_pin_r} : 32'h00000000;

  // APB answer with one wait state; unmapped addresses answer with an error.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & ~hit_any;
      prdata_r  <= apb_setup ? rd_mux : 32'h00000000;
    end
  end

  // Software registers; a refused start wins over a clear in the same cycle.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr_r    <= '0;
      wdata_r   <= '0;
      rst_pin_r <= 1'b1;
      wp_pin_r  <= 1'b1;
      refused_r <= 1'b0;
    end else begin
      if (apb_commit & hit_addr)  addr_r  <= pwdata_i[ADDR_W-1:0];
      if (apb_commit & hit_wdata) wdata_r <= pwdata_i[DATA_W-1:0];
      if (apb_commit & hit_pins) begin
        rst_pin_r <= pwdata_i[`FCS_PIN_RESET];
        wp_pin_r  <= pwdata_i[`FCS_PIN_WPROT];
      end
      refused_r <= (start_req & ~start_ok) | (refused_r & ~refuse_clr);
    end
  end

  // Recovery wait after the powerdown reset pin goes high again.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rec_cnt_r <= 16'h0000;
    end else if (!rst_pin_r) begin
      rec_cnt_r <= T_RS_C;
    end else if (recovering) begin
      rec_cnt_r <= rec_cnt_r - 16'h0001;
    end
  end

  // Device sequencer tracking: busy from a started job until a poll reads ready.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !rst_pin_r) begin
      dev_busy_r <= 1'b0; // Reset aborts any device job; software must repeat it.
      susp_r     <= 1'b0;
    end else begin
      if (start && op_starts_work(new_op)) dev_busy_r <= 1'b1;
      else if (poll_rdy) dev_busy_r <= 1'b0;
      if (start && new_op == `FCS_OP_SUSPEND) susp_r <= 1'b1;
      else if (start && new_op == `FCS_OP_RESUME) susp_r <= 1'b0;
    end
  end

  // Bus engine: walks the steps of the current operation over the flash pins.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !rst_pin_r) begin
      state_r    <= ST_IDLE;
      eng_busy_r <= 1'b0;
      op_r       <= `FCS_OP_RD_ARRAY;
      idx_r      <= 3'd0;
      cnt_r      <= 8'h00;
      rdata_r    <= '0;
      sr_r       <= 8'h00;
      fl_addr_o  <= '0;
      fl_dq_o    <= '0;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            op_r       <= new_op;
            idx_r      <= 3'd0;
            eng_busy_r <= 1'b1;
            state_r    <= ST_STEP;
          end
        end
        ST_STEP: begin
          fl_addr_o <= addr_r; // Erase confirm and lock query carry the block address.
          case (cur_step.kind)
            K_WCMD, K_WDAT: begin
              fl_dq_o    <= (cur_step.kind == K_WCMD) ? DATA_W'(cur_step.code) : wdata_r;
              fl_dq_oe_o <= 1'b1;
              fl_ce_n_o  <= 1'b0;
              fl_we_n_o  <= 1'b0;
              cnt_r      <= T_WP_C - 8'h01;
              state_r    <= ST_WR_LOW;
            end
            K_READ, K_POLL: begin
              fl_ce_n_o <= 1'b0;
              fl_oe_n_o <= 1'b0;
              cnt_r     <= T_ACC_C - 8'h01;
              state_r   <= ST_RD_LOW;
            end
            default: begin
              eng_busy_r <= 1'b0;
              state_r    <= ST_IDLE;
            end
          endcase
        end
        ST_WR_LOW: begin
          if (cnt_r == 8'h00) begin
            fl_we_n_o <= 1'b1;
            fl_ce_n_o <= 1'b1; // Chip deselected between cycles lets the device idle.
            idx_r     <= idx_r + 3'd1;
            cnt_r     <= T_WPH_C - 8'h01;
            state_r   <= ST_GAP;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_RD_LOW: begin
          if (cnt_r == 8'h00) begin
            // Each poll read toggles output enable and chip select to refresh status.
            fl_oe_n_o <= 1'b1;
            fl_ce_n_o <= 1'b1;
            if (cur_step.kind == K_READ) rdata_r <= fl_dq_i;
            else sr_r <= fl_dq_i[7:0];
            if (cur_step.kind == K_READ || fl_dq_i[`FCS_SR_READY]) idx_r <= idx_r + 3'd1;
            cnt_r   <= T_WPH_C - 8'h01;
            state_r <= ST_GAP;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_GAP: begin
          if (cnt_r == 8'h00) begin
            fl_dq_oe_o <= 1'b0;
            state_r    <= ST_STEP;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Pin and APB outputs, all taken from flip-flops.
  assign powerdown_reset_n_o = rst_pin_r;
  assign fl_wp_n_o           = wp_pin_r;
  assign prdata_o            = prdata_r;
  assign pready_o            = pready_r;
  assign pslverr_o           = pslverr_r;

endmodule
`default_nettype wire

/* File: shared/fcs_consts.svh */
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// Clock rate and the conversion of a least time into whole clock cycles.
`define FCS_CLK_MHZ          200
`define FCS_NS_PER_US        1000
`define FCS_NS2CYC(ns)       ((((ns) * `FCS_CLK_MHZ) + `FCS_NS_PER_US - 1) / `FCS_NS_PER_US)

// Flash bus timing in nanoseconds (least times).
`define FCS_T_WP_NS          50
`define FCS_T_WPH_NS         30
`define FCS_T_ACC_NS         90
`define FCS_T_RS_NS          150

// Register byte offsets on the APB side.
`define FCS_REG_CTRL         8'h00
`define FCS_REG_ADDR         8'h04
`define FCS_REG_WDATA        8'h08
`define FCS_REG_RDATA        8'h0c
`define FCS_REG_STATUS       8'h10
`define FCS_REG_PINS         8'h14

// Field positions.
`define FCS_ST_ENG_BUSY      0
`define FCS_ST_DEV_BUSY      1
`define FCS_ST_REFUSED       2
`define FCS_ST_RECOVER       3
`define FCS_ST_SUSP          4
`define FCS_ST_SR_LSB        8
`define FCS_PIN_RESET        0
`define FCS_PIN_WPROT        1
`define FCS_SR_READY         7

// Operation codes written to the control register.
`define FCS_OP_RD_ARRAY      4'h0
`define FCS_OP_RD_STATUS     4'h1
`define FCS_OP_PROGRAM       4'h2
`define FCS_OP_ERASE         4'h3
`define FCS_OP_SUSPEND       4'h4
`define FCS_OP_RESUME        4'h5
`define FCS_OP_OTP_ENTER     4'h6
`define FCS_OP_OTP_EXIT      4'h7
`define FCS_OP_OTP_PROG      4'h8
`define FCS_OP_PROTECT       4'h9
`define FCS_OP_CLR_STATUS    4'ha
`define FCS_OP_POLL          4'hb
`define FCS_OP_RD_RAW        4'hc

// Flash command codes.
`define FCS_CMD_READ_ARRAY   8'hff
`define FCS_CMD_READ_STATUS  8'h70
`define FCS_CMD_PROG_SETUP   8'h40
`define FCS_CMD_ERASE_SETUP  8'h20
`define FCS_CMD_CONFIRM      8'hd0
`define FCS_CMD_SUSPEND      8'hb0
`define FCS_CMD_OTP          8'haf
`define FCS_CMD_PROTECT      8'h0f
`define FCS_CMD_CLR_STATUS   8'h50
`define FCS_CMD_NONE         8'h00

`endif

/* File: shared/fcs_pkg.sv */
`default_nettype none
package fcs_pkg;
  // Kind of one bus step in an operation's sequence.
  typedef enum logic [2:0] {
    K_END, K_WCMD, K_WDAT, K_READ, K_POLL
  } fcs_kind_t;

  // One step: its kind and, for a command write, the code.
  typedef struct packed {
    fcs_kind_t  kind;
    logic [7:0] code;
  } fcs_step_t;

  // Bus engine states.
  typedef enum {
    ST_IDLE, ST_STEP, ST_WR_LOW, ST_RD_LOW, ST_GAP
  } fcs_state_t;
endpackage
`default_nettype wire

/* File: verif/fcs_flash_host_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_host_sva (
  // Observed ports.
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        fl_dq_oe_o,
  input  wire logic        fl_ce_n_o,
  input  wire logic        fl_oe_n_o,
  input  wire logic        fl_we_n_o,
  input  wire logic        powerdown_reset_n_o,
  input  wire logic        fl_wp_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // A committed write to the pin register.
  wire logic pins_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h14;

  sequence s_we_low10;
    !fl_we_n_o [*8] ##1 !fl_we_n_o [*2] ##1 fl_we_n_o;
  endsequence
  sequence s_oe_low18;
    !fl_oe_n_o [*8] ##1 !fl_oe_n_o [*8] ##1 !fl_oe_n_o [*2] ##1 fl_oe_n_o;
  endsequence

  chk_apb_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no answer");
  chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  chk_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i)) else $error("stray ready");
  chk_unmapped_err: assert property (pready_o && paddr_i > 8'h14 |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped not refused");
  chk_idle_quiet: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o) else $error("idle data");
  chk_pins_follow: assert property (pins_wr |=> powerdown_reset_n_o == $past(pwdata_i[0]) &&
    fl_wp_n_o == $past(pwdata_i[1])) else $error("pin mismatch");
  chk_write_width: assert property ($fell(fl_we_n_o) |-> s_we_low10) else $error("write width");
  chk_read_width: assert property ($fell(fl_oe_n_o) |-> s_oe_low18) else $error("read width");
  chk_write_drive: assert property (!fl_we_n_o |-> fl_dq_oe_o && !fl_ce_n_o) else $error("write undriven");
  chk_read_clash: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o) else $error("bus clash");
  chk_reset_hold: assert property (!powerdown_reset_n_o && $past(!powerdown_reset_n_o) |->
    fl_we_n_o && fl_oe_n_o) else $error("access in reset");
endmodule
bind fcs_flash_host fcs_flash_host_sva i_fcs_flash_host_sva (.clk_sys_i, .srst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .fl_dq_oe_o, .fl_ce_n_o, .fl_oe_n_o,
  .fl_we_n_o, .powerdown_reset_n_o, .fl_wp_n_o);
`default_nettype wire

/* File: verif/fcs_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
  // Factory half of the one-time area; the value is arbitrary.
  parameter logic [15:0] FACTORY_W = 16'h0000
) (
  // Host side pins.
  input  wire logic [19:0] a_i,
  input  wire logic [15:0] d_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        wp_n_i,
  // Status reads that a job stays busy.
  input  wire logic [3:0]  lat_i,
  output logic      [15:0] q_o
);
  logic [15:0] mem [16];
  logic [15:0] otp [8];
  logic [15:0] pd;
  logic [7:0]  pend;
  logic [4:0]  left;
  logic [3:0]  pa;
  logic [6:0]  oa;
  logic [3:0]  lk;
  logic        susp, er, sr1, stat, om, po, olk;
  // A cycle starts when the later of select and strobe falls and ends when the first of them rises.
  wire logic   wr_n = we_n_i | ce_n_i;
  wire logic   rd_n = oe_n_i | ce_n_i;

  // Clears the sequencer and status and returns to array reads.
  task automatic init();
    left = 5'd0; susp = 1'b0; er = 1'b0; sr1 = 1'b0;
    stat = 1'b0; pend = 8'h00; lk = 4'hf; om = 1'b0; po = 1'b0;
  endtask

  initial begin
    q_o = 16'h0000;
    for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    for (int i = 0; i < 8; i++) otp[i] = (i < 4) ? FACTORY_W : 16'hffff;
    olk = 1'b1;
    init();
  end

  always @(negedge rst_n_i) init();

  // Latches each command or data word when the selected write cycle ends.
  always @(posedge wr_n) begin
    if (rst_n_i) begin
      if (left != 5'd0 && !susp) begin
        if (d_i[7:0] == 8'hb0) susp = 1'b1;
      end else if (pend == 8'h40 || pend == 8'h20) begin
        if (lk[a_i[3:2]] && !wp_n_i) sr1 = 1'b1;
        else if (pend == 8'h40 || d_i[7:0] == 8'hd0) begin
          pa = a_i[3:0]; oa = a_i[6:0]; po = om; pd = d_i; er = pend == 8'h20; left = lat_i + 5'd1;
        end
        pend = 8'h00;
      end else if (pend == 8'h0f) begin
        lk[a_i[3:2]] = d_i[0];
        pend = 8'h00;
      end else begin
        if (d_i[7:0] == 8'hd0) susp = 1'b0;
        sr1 = sr1 && d_i[7:0] != 8'h50;
        om = (om || (pend == 8'haf && d_i[7:0] == 8'haf)) && !(pend == 8'hff && d_i[7:0] == 8'hff);
        stat = d_i[7:0] != 8'hff && d_i[7:0] != 8'haf;
        pend = d_i[7:0];
      end
    end
  end

  // Each status read advances a running job; the last one applies it.
  always @(negedge rd_n) begin
    if (rst_n_i) begin
      if (stat && left != 5'd0 && !susp) begin
        left = left - 5'd1;
        if (left == 5'd0 && er) for (int i = 0; i < 4; i++) mem[{pa[3:2], i[1:0]}] = 16'hffff;
        if (left == 5'd0 && !er && !po) mem[pa] = mem[pa] & pd;
        if (left == 5'd0 && !er && po && oa == 7'h40) olk = olk & pd[15];
        if (left == 5'd0 && !er && po && oa[2] && olk) otp[oa[2:0]] = otp[oa[2:0]] & pd;
      end
      // The output keeps the last word read until the next read cycle.
      q_o = stat ? {8'h00, left == 5'd0 || susp, susp && er, 3'b000, susp && !er, sr1, 1'b0}
                 : (om ? otp[a_i[2:0]] : mem[a_i[3:0]]);
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [1:0] pins; logic [3:0] op; logic [19:0] a; logic [15:0] d; logic [3:0] lat; logic chk; logic [15:0] exp;
  } fcs_row_t;
  // Factory half of the one-time area as the model holds it; the value is arbitrary.
  localparam logic [15:0] FACTORY_W = 16'h3c5a;
  // Pins, op, address, data, busy polls, check flag, expected read.
  fcs_row_t rows [31] = '{
    '{2'h3, 4'h2, 20'h3, 16'h00f0, 4'h0, 1'b0, 16'h0}, '{2'h3, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h3, 4'h0, 20'h3, 16'h0, 4'h0, 1'b1, 16'h00f0}, '{2'h3, 4'h2, 20'h3, 16'h0ff0, 4'h3, 1'b0, 16'h0},
    '{2'h3, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0}, '{2'h3, 4'h0, 20'h3, 16'h0, 4'h0, 1'b1, 16'h00f0},
    '{2'h3, 4'h3, 20'h1, 16'h0, 4'h2, 1'b0, 16'h0}, '{2'h3, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h3, 4'h0, 20'h3, 16'h0, 4'h0, 1'b1, 16'hffff}, '{2'h3, 4'h1, 20'h0, 16'h0, 4'h0, 1'b1, 16'h0080},
    '{2'h1, 4'h2, 20'h6, 16'h0, 4'h0, 1'b0, 16'h0}, '{2'h1, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h1, 4'h1, 20'h6, 16'h0, 4'h0, 1'b1, 16'h0082}, '{2'h1, 4'ha, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h1, 4'h9, 20'h6, 16'h0, 4'h0, 1'b0, 16'h0}, '{2'h1, 4'h2, 20'h6, 16'h1234, 4'h0, 1'b0, 16'h0},
    '{2'h1, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0}, '{2'h1, 4'h0, 20'h6, 16'h0, 4'h0, 1'b1, 16'h1234},
    '{2'h3, 4'h8, 20'h5, 16'h1234, 4'h0, 1'b0, 16'h0}, '{2'h3, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h3, 4'h8, 20'h1, 16'h0, 4'h0, 1'b0, 16'h0}, '{2'h3, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h3, 4'h8, 20'h40, 16'h7fff, 4'h0, 1'b0, 16'h0}, '{2'h3, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h3, 4'h8, 20'h5, 16'h0, 4'h0, 1'b0, 16'h0}, '{2'h3, 4'hb, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h3, 4'h7, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0}, '{2'h3, 4'h6, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0},
    '{2'h3, 4'hc, 20'h5, 16'h0, 4'h0, 1'b1, 16'h1234}, '{2'h3, 4'hc, 20'h1, 16'h0, 4'h0, 1'b1, FACTORY_W},
    '{2'h3, 4'h7, 20'h0, 16'h0, 4'h0, 1'b0, 16'h0}};
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [19:0] fl_addr;
  logic [15:0] dq_o, dq_i, q;
  logic        dq_oe, ce_n, oe_n, we_n, pd_rst_n, wp_n;
  logic [3:0]  lat = 4'h0;
  int          miscompares = 0;
  int          checks_done = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;
  // The data wire: host when driving, else the device, else the inverse of the last value.
  assign dq_i = dq_oe ? dq_o : (!ce_n && !oe_n ? q : ~q);

  fcs_flash_host #(.T_RS_NS(100)) i_fcs_flash_host (.clk_sys_i, .srst_i, .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .fl_addr_o(fl_addr), .fl_dq_i(dq_i), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe),
    .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n), .powerdown_reset_n_o(pd_rst_n), .fl_wp_n_o(wp_n));
  fcs_flash_model #(.FACTORY_W(FACTORY_W)) i_fcs_flash_model (.a_i(fl_addr), .d_i(dq_i), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n),
    .rst_n_i(pd_rst_n), .wp_n_i(wp_n), .lat_i(lat), .q_o(q));

  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // One APB transfer; read data and error land in r and err.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (pready !== 1'b1 && n < 50);
    r = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin $display("Error at %0t: bus hang", $time); miscompares++; conclude(); end
  endtask

  // Polls the engine-busy flag; the last status read stays in r.
  task automatic op(input logic [3:0] o);
    int n;
    apb(1'b1, 8'h00, {28'h0, o});
    n = 0;
    do begin apb(1'b0, 8'h10, 32'h0); n++; end while (r[0] !== 1'b0 && n < 200);
    if (n >= 200) begin $display("Error at %0t: engine hang", $time); miscompares++; conclude(); end
  endtask

  // Table cases first, then a busy refusal, suspension, the reset pin, a recovery refusal and a second reset.
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    foreach (rows[i]) begin
      lat <= rows[i].lat;
      apb(1'b1, 8'h14, {30'h0, rows[i].pins});
      apb(1'b1, 8'h04, {12'h0, rows[i].a});
      apb(1'b1, 8'h08, {16'h0, rows[i].d});
      op(rows[i].op);
      if (rows[i].chk) begin
        apb(1'b0, 8'h0c, 32'h0);
        cmp(r, {16'h0, rows[i].exp});
      end
    end
    lat <= 4'h8;
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b1, 8'h04, 32'h8);
    apb(1'b1, 8'h08, 32'h00ff);
    apb(1'b1, 8'h00, 32'h2);
    op(4'h0);
    cmp(r & 32'h4, 32'h4);
    op(4'h4);
    cmp(r & 32'h10, 32'h10);
    op(4'h5);
    op(4'hb);
    cmp(r & 32'h12, 32'h0);
    op(4'h0);
    apb(1'b0, 8'h0c, 32'h0);
    cmp(r, 32'h00ff);
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h14, 32'h2);
    @(posedge clk_sys_i);
    cmp({31'h0, pd_rst_n}, 32'h0);
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    cmp(r & 32'hc, 32'hc);
    apb(1'b0, 8'h40, 32'h0);
    cmp({err, r[30:0]}, 32'h80000000);
    apb(1'b1, 8'h14, 32'h0);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    cmp({26'h0, pd_rst_n, wp_n, ce_n, we_n, oe_n, dq_oe}, 32'h3e);
    conclude();
  end
endmodule
`default_nettype wire
